// ==== rtl/ttc_defines.vh ====
// constants for the thermal throttle controller
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH
`define TTC_ADDR_W        4
`define TTC_OFS_CTRL      4'h0
`define TTC_OFS_ODM       4'h1
`define TTC_OFS_PERF      4'h2
`define TTC_OFS_THR       4'h3
`define TTC_OFS_STAT      4'h4
`define TTC_OFS_TEMP      4'h5
`define TTC_OFS_ID        4'h6
`define TTC_CTRL_AUTO_CM  0
`define TTC_CTRL_AUTO_FS  1
`define TTC_CTRL_FORCE_CM 2
`define TTC_CTRL_ADAPT    3
`define TTC_CTRL_IE_ASRT  4
`define TTC_CTRL_IE_DEAS  5
`define TTC_CTRL_IE_OOS   6
`define TTC_CTRL_IE_THR0  7
`define TTC_CTRL_IE_THR1  8
`define TTC_CTRL_RST      9'h003
`define TTC_ODM_EN        4
`define TTC_ODM_DUTY_HI   3
`define TTC_ODM_DUTY_LO   1
`define TTC_ODM_RST       5'h00
`define TTC_PERF_RST      3'h7
`define TTC_LOW_PT_RST    3'h1
`define TTC_THR_RST       16'h1008
`define TTC_ST_ALERT      0
`define TTC_ST_OOS        1
`define TTC_ST_OOS_STKY   2
`define TTC_ST_ASRT       3
`define TTC_ST_DEAS       4
`define TTC_ST_THR0       5
`define TTC_ST_THR1       6
`define TTC_MOD_PER       3'h7
`define TTC_SEARCH_CYC    8'hff
`define TTC_OOS_CYC       8'hff
`define TTC_ID_VAL        32'h0000_5a17
`endif

// ==== rtl/ttc_top.v ====
// thermal throttle controller with avalon-mm register slave
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ttc_defines.vh"

//
// Contract
// RULE1: adaptive mode steps down one point at a time, then searches upward again; on cooling the point returns straight to sw_req instead.
// RULE2: with both auto modes enabled, frequency stepping wins over modulation.
// RULE3: force option adds modulation when stepping alone fails to cool.
// RULE4: software target above thermal target waits until thermal event ends.
// RULE5: software target below thermal target is applied at once.
// RULE6: on-demand enable bit 4 activates throttling regardless of temperature.
// RULE7: on-demand duty from 3-bit field, 12.5% to 87.5% in eighths.
// RULE8: automatic modulation uses fixed 50% on, 50% off.
// RULE9: auto mode under high temperature takes precedence over on-demand.
// RULE10: alert pin asserted when die temperature exceeds trip point.
// RULE11: optional interrupt on alert pin assertion and on deassertion.
// RULE12: no new alert in low power; existing alert held until exit and cool.
// RULE13: catastrophic temperature asserts trip output, independent of activity.
// RULE14: sensor reading is relative to maximum, never above, valid in normal state.
// RULE15: sensor reaching maximum activates enabled hardware throttling.
// RULE16: throttled and still hot latches flag_a flag, sticky copy, interrupt.
// RULE17: two programmable thresholds whose crossing can raise interrupts.
// RULE18: one package alert pin driven when either core trips.
// RULE19: modulation-only mode modulates solely the hot core, pin still asserted.
// RULE20: stepping mode moves both cores to lowest programmed thermal point.
// RULE21: external pin pull activates throttling; modulation-only hits both cores.
// RULE22: external pin with stepping: both cores lowest point, force ignored.
// RULE23: stepping returns to last requested point once temperature drops.
module ttc_top (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  input  wire [1:0]  i_core_hot,
  input  wire        i_catastrophic,
  input  wire [13:0] i_core_temp,
  input  wire        i_low_power,
  input  wire        i_thermal_alert_pin_in,
  output reg         o_thermal_alert_pin_out,
  output reg         o_thermal_alert_pin_oe,
  output reg         o_catastrophic_trip_out,
  output reg  [1:0]  o_core_clk_en,
  output reg  [2:0]  o_perf_point,
  output reg         o_irq_local
);

  reg        rst_meta;
  reg        rst_sync;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire rst_b = rst_sync;

  reg [8:0]  ctrl;
  reg [4:0]  odm;
  reg [2:0]  sw_req;
  reg [2:0]  low_pt;
  reg [15:0] thr;
  reg [6:0]  stat;
  reg [2:0]  mod_cnt;
  reg [2:0]  therm_pt;
  reg [7:0]  search_cnt;
  reg [7:0]  oos_cnt;
  reg        alert_q;
  reg [1:0]  thr_above;
  reg        step_act;

  // sensor offsets saturate at zero: reading never exceeds maximum [RULE14]
  wire [6:0] temp0 = i_core_temp[6:0];
  wire [6:0] temp1 = i_core_temp[13:7];
  wire [6:0] tmin  = (temp0 < temp1) ? temp0 : temp1;
  wire       dts_max0 = i_core_hot[0] | (temp0 == 7'h00); // [RULE15]
  wire       dts_max1 = i_core_hot[1] | (temp1 == 7'h00); // [RULE15]
  wire [1:0] hot = {dts_max1, dts_max0};
  wire       any_hot = |hot; // [RULE18]
  wire       ext_hot = ~i_thermal_alert_pin_in & ~o_thermal_alert_pin_oe;
  wire       auto_cm = ctrl[`TTC_CTRL_AUTO_CM];
  wire       auto_fs = ctrl[`TTC_CTRL_AUTO_FS];
  wire       force_cm = ctrl[`TTC_CTRL_FORCE_CM];
  wire       adapt = ctrl[`TTC_CTRL_ADAPT];
  wire       odm_en = odm[`TTC_ODM_EN]; // [RULE6]
  wire [2:0] odm_duty = odm[`TTC_ODM_DUTY_HI:`TTC_ODM_DUTY_LO];
  wire       auto_on = auto_cm | auto_fs;
  wire       thermal = any_hot | ext_hot;

  // alert pin: no new assertion in low power, held while hot [RULE12]
  wire next_alert = alert_q ? (any_hot | i_low_power)
                            : (any_hot & ~i_low_power); // [RULE10]

  // stepping preferred over modulation when both enabled [RULE2]
  wire next_step = auto_fs & thermal; // [RULE20] [RULE22]
  // force adds modulation only for internal trips [RULE3] [RULE22]
  wire force_add = auto_fs & force_cm & any_hot & oos_cnt == `TTC_OOS_CYC;
  // modulation-only: hot cores, or both cores on external pull [RULE19] [RULE21]
  wire [1:0] auto_mod = (auto_cm & ~auto_fs) ?
                        (ext_hot ? 2'b11 : hot) :
                        (force_add ? hot : 2'b00);
  // auto under heat beats on-demand [RULE9]
  wire auto_heat = auto_on & thermal;
  wire half_on  = mod_cnt < 3'h4; // [RULE8]
  // duty n gives n of 8 cycles on
  wire odm_on   = mod_cnt < odm_duty; // [RULE7]
  reg  [1:0] next_clk_en;
  always @* begin
    next_clk_en = 2'b11;
    if (auto_heat) begin
      next_clk_en = half_on ? 2'b11 : ~auto_mod; // [RULE8]
    end else if (odm_en && odm_duty != 3'h0) begin
      next_clk_en = odm_on ? 2'b11 : 2'b00; // [RULE6] [RULE7]
    end
  end

  // thermal target: lowest, or adaptive step down; an upward step lands only in the last cycle of step_act [RULE1]
  reg [2:0] next_therm_pt;
  always @* begin
    next_therm_pt = therm_pt;
    if (!step_act) begin
      next_therm_pt = adapt ? o_perf_point : low_pt;
    end else if (!adapt || ext_hot) begin
      next_therm_pt = low_pt; // [RULE20] [RULE22]
    end else if (search_cnt == `TTC_SEARCH_CYC) begin
      if (any_hot && therm_pt > low_pt)
        next_therm_pt = therm_pt - 3'h1; // [RULE1]
      else if (!any_hot && therm_pt < sw_req)
        next_therm_pt = therm_pt + 3'h1; // [RULE1]
    end
  end

  // lower software request applies now, higher waits [RULE4] [RULE5]
  wire [2:0] next_perf = step_act ?
                         ((sw_req < therm_pt) ? sw_req : therm_pt) :
                         sw_req; // [RULE23]

  wire bus_acc = (i_avs_read | i_avs_write) & o_avs_waitrequest;
  // write lands on the edge where waitrequest is seen low
  wire wr = i_avs_write & ~o_avs_waitrequest;
  wire rd = i_avs_read & o_avs_waitrequest;
  wire alert_rise = next_alert & ~alert_q;
  wire alert_fall = ~next_alert & alert_q;
  wire [1:0] thr_cross = {tmin <= thr[14:8], tmin <= thr[6:0]};
  wire oos_ev = (step_act | ~&next_clk_en) & any_hot &
                oos_cnt == `TTC_OOS_CYC; // [RULE16]
  wire st_clr = wr && i_avs_address == `TTC_OFS_STAT && i_avs_byteenable[0];
  wire [6:0] clr_mask = st_clr ? i_avs_writedata[6:0] : 7'h00;
  // hardware sets win over write-one-to-clear
  wire [6:0] set_v = {thr_cross[1] & ~thr_above[1],
                      thr_cross[0] & ~thr_above[0], // [RULE17]
                      alert_fall, alert_rise, // [RULE11]
                      oos_ev, 1'b0, 1'b0};
  wire [6:0] next_stat = {(stat[6:3] & ~clr_mask[6:3]) | set_v[6:3],
                          (stat[2] & ~clr_mask[2]) | oos_ev,
                          any_hot & (stat[1] | oos_ev),
                          next_alert};
  wire next_irq = (stat[3] & ctrl[`TTC_CTRL_IE_ASRT]) |
                  (stat[4] & ctrl[`TTC_CTRL_IE_DEAS]) |
                  (stat[2] & ctrl[`TTC_CTRL_IE_OOS]) |
                  (stat[5] & ctrl[`TTC_CTRL_IE_THR0]) |
                  (stat[6] & ctrl[`TTC_CTRL_IE_THR1]);

  reg [31:0] rdata;
  always @* begin
    case (i_avs_address)
      `TTC_OFS_CTRL: rdata = {23'h0, ctrl};
      `TTC_OFS_ODM:  rdata = {27'h0, odm};
      `TTC_OFS_PERF: rdata = {13'h0, o_perf_point, 1'b0, therm_pt,
                              1'b0, low_pt, 5'h00, sw_req};
      `TTC_OFS_THR:  rdata = {16'h0, thr};
      `TTC_OFS_STAT: rdata = {25'h0, stat};
      // readout valid only outside low power [RULE14]
      `TTC_OFS_TEMP: rdata = {15'h0, ~i_low_power, 1'b0, temp1, 1'b0, temp0};
      `TTC_OFS_ID:   rdata = `TTC_ID_VAL; // arbitrary value
      default:       rdata = 32'h0;
    endcase
  end

  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `TTC_CTRL_RST;
      odm <= `TTC_ODM_RST;
      sw_req <= `TTC_PERF_RST;
      low_pt <= `TTC_LOW_PT_RST;
      thr <= `TTC_THR_RST;
      stat <= 7'h00;
      mod_cnt <= 3'h0;
      therm_pt <= `TTC_PERF_RST;
      search_cnt <= 8'h00;
      oos_cnt <= 8'h00;
      alert_q <= 1'b0;
      thr_above <= 2'b00;
      step_act <= 1'b0;
      o_avs_readdata <= 32'h0;
      o_avs_waitrequest <= 1'b1;
      o_thermal_alert_pin_out <= 1'b1;
      o_thermal_alert_pin_oe <= 1'b0;
      o_catastrophic_trip_out <= 1'b0;
      o_core_clk_en <= 2'b11;
      o_perf_point <= `TTC_PERF_RST;
      o_irq_local <= 1'b0;
    end else begin
      // one wait cycle, then acknowledge
      o_avs_waitrequest <= ~(bus_acc & o_avs_waitrequest) | ~o_avs_waitrequest;
      if (rd)
        o_avs_readdata <= rdata;
      if (wr && i_avs_byteenable[0]) begin
        case (i_avs_address)
          `TTC_OFS_CTRL: ctrl[7:0] <= i_avs_writedata[7:0];
          `TTC_OFS_ODM:  odm <= i_avs_writedata[4:0]; // [RULE6]
          `TTC_OFS_PERF: sw_req <= i_avs_writedata[2:0];
          `TTC_OFS_THR:  thr[7:0] <= i_avs_writedata[7:0]; // [RULE17]
          default: ;
        endcase
      end
      if (wr && i_avs_byteenable[1]) begin
        case (i_avs_address)
          `TTC_OFS_CTRL: ctrl[8] <= i_avs_writedata[8];
          `TTC_OFS_PERF: low_pt <= i_avs_writedata[10:8];
          `TTC_OFS_THR:  thr[15:8] <= i_avs_writedata[15:8];
          default: ;
        endcase
      end
      stat <= next_stat;
      thr_above <= thr_cross;
      mod_cnt <= mod_cnt + 3'h1;
      step_act <= next_step;
      therm_pt <= next_therm_pt;
      // pacing of adaptive search and flag_a dwell
      search_cnt <= (step_act && search_cnt != `TTC_SEARCH_CYC) ?
                    search_cnt + 8'h01 : 8'h00;
      oos_cnt <= (any_hot && oos_cnt != `TTC_OOS_CYC) ?
                 oos_cnt + 8'h01 : (any_hot ? oos_cnt : 8'h00);
      alert_q <= next_alert;
      o_thermal_alert_pin_out <= 1'b0;
      o_thermal_alert_pin_oe <= next_alert; // [RULE10] [RULE18]
      // trip latches until reset; no bus traffic needed [RULE13]
      o_catastrophic_trip_out <= o_catastrophic_trip_out | i_catastrophic;
      o_core_clk_en <= i_catastrophic ? 2'b00 : next_clk_en; // [RULE13]
      o_perf_point <= next_perf; // [RULE4] [RULE5] [RULE23]
      o_irq_local <= next_irq; // [RULE11] [RULE16] [RULE17]
    end
  end

endmodule // ttc_top

// ==== test/ttc_sva.sv ====
// port checker for the thermal throttle controller
`timescale 1ns/1ps
module ttc_chk (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  input wire logic [1:0] i_core_hot,
  input wire logic       i_catastrophic,
  input wire logic       i_low_power,
  input wire logic       o_thermal_alert_pin_out,
  input wire logic       o_thermal_alert_pin_oe,
  input wire logic       o_catastrophic_trip_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_wait_answer: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
  a_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_alert_on_hot: assert property ((|i_core_hot && !i_low_power) [*6]
    |-> o_thermal_alert_pin_oe) else $error("alert not driven");
  a_pin_drive_low: assert property (o_thermal_alert_pin_oe
    |-> !o_thermal_alert_pin_out) else $error("alert not low");
  a_lp_no_new: assert property ((i_low_power && !o_thermal_alert_pin_oe) [*3]
    |=> !o_thermal_alert_pin_oe) else $error("alert raised in low power");
  a_lp_alert_hold: assert property (o_thermal_alert_pin_oe && i_low_power
    |=> o_thermal_alert_pin_oe) else $error("alert dropped in low power");
  a_trip_rise: assert property ($rose(i_catastrophic)
    |-> ##[1:3] o_catastrophic_trip_out) else $error("trip missing");
  a_trip_hold: assert property (o_catastrophic_trip_out
    |=> o_catastrophic_trip_out) else $error("trip released");
  c_read: cover property (i_avs_read && !o_avs_waitrequest);
  c_alert: cover property ($rose(o_thermal_alert_pin_oe));
  c_trip: cover property ($rose(o_catastrophic_trip_out));
endmodule // ttc_chk
bind ttc_top ttc_chk u_ttc_chk (.i_clk, .i_rst_b, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_core_hot, .i_catastrophic, .i_low_power,
  .o_thermal_alert_pin_out, .o_thermal_alert_pin_oe, .o_catastrophic_trip_out);

// ==== test/ttc_board_mon.sv ====
// board thermal monitor sharing the open-drain alert wire
`timescale 1ns/1ps
module ttc_board_mon (
  input  wire logic i_clk,
  input  wire logic i_pull,
  input  wire logic i_oe,
  input  wire logic i_out,
  output logic      o_pin
);
  logic pull_q = 1'b0;
  // slow monitor: pull lags its cause by a cycle
  always @(posedge i_clk) pull_q <= i_pull;
  // wired-and with board pull-up
  assign o_pin = !((i_oe && !i_out) || pull_q);
endmodule // ttc_board_mon

// ==== test/ttc_top_tb.sv ====
// self-checking bench for the thermal throttle controller
`timescale 1ns/1ps
module ttc_top_tb;
  logic        i_clk = 0, i_rst_b = 0, rd = 0, wr = 0, pull = 0, lp = 0;
  logic        cat = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, q;
  logic [1:0]  hot = 2'h0;
  logic [13:0] temp = 14'h3fff;
  wire  [31:0] rdat;
  wire  [1:0]  cen;
  wire  [2:0]  perf;
  wire         wait_r, pin, pout, poe, trip, irq;
  int          err_count = 0, tests_run = 0, n;
  always #2 i_clk = ~i_clk;
  ttc_top u_ttc_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r), .i_core_hot(hot), .i_catastrophic(cat),
    .i_core_temp(temp), .i_low_power(lp), .i_thermal_alert_pin_in(pin),
    .o_thermal_alert_pin_out(pout), .o_thermal_alert_pin_oe(poe),
    .o_catastrophic_trip_out(trip), .o_core_clk_en(cen),
    .o_perf_point(perf), .o_irq_local(irq));
  ttc_board_mon u_ttc_board_mon (.i_clk(i_clk), .i_pull(pull), .i_oe(poe),
    .i_out(pout), .o_pin(pin));
  task end_of_test;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  // held until waitrequest is seen low at a rising edge
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do @(posedge i_clk); while (wait_r !== 1'b0);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  // 64 cycles is a whole number of 8-cycle modulation periods
  task cnt(input int c, output int k);
    k = 0;
    repeat (8) @(negedge i_clk);
    repeat (64) begin
      @(negedge i_clk);
      k += int'(cen[c] === 1'b1);
    end
  endtask
  task heat(input logic [1:0] h);
    @(posedge i_clk);
    hot <= h;
    temp <= {h[1] ? 7'h00 : 7'h7f, h[0] ? 7'h00 : 7'h7f};
    repeat (20) @(posedge i_clk);
  endtask
  initial begin
    #100000;
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk("perf rst", 32'h7, perf);
    chk("clk_en rst", 32'h3, cen);
    acc(0, 4'h0, 0); chk("ctrl rst", 32'h003, q[8:0]);
    acc(0, 4'h3, 0); chk("thr rst", 32'h1008, q[15:0]);
    acc(1, 4'h7, 32'hffff); acc(0, 4'h7, 0); chk("unmapped", 0, q);
    acc(1, 4'h0, 0);
    for (int d = 1; d < 8; d++) begin
      acc(1, 4'h1, 32'h10 | (d << 1)); cnt(0, n); chk("odm", d * 8, n);
    end
    acc(1, 4'h1, 0); acc(1, 4'h0, 32'h11); heat(2'h1);
    chk("alert oe", 1, poe); chk("irq", 1, irq);
    cnt(0, n); chk("auto duty", 32, n);
    cnt(1, n); chk("cool core", 64, n);
    acc(1, 4'h1, 32'h12); cnt(0, n); chk("auto wins", 32, n);
    acc(1, 4'h1, 0); heat(2'h0); acc(1, 4'h0, 32'h3); heat(2'h2);
    chk("step low", 1, perf);
    cnt(1, n); chk("step no mod", 64, n);
    acc(1, 4'h2, 32'h105); repeat (20) @(posedge i_clk);
    chk("sw held", 1, perf);
    heat(2'h0); chk("sw after", 5, perf);
    heat(2'h1); acc(1, 4'h2, 32'h100); repeat (20) @(posedge i_clk);
    chk("sw lower", 0, perf);
    heat(2'h0); acc(1, 4'h2, 32'h107); acc(1, 4'h0, 32'h7); heat(2'h1);
    repeat (300) @(posedge i_clk);
    cnt(0, n); chk("force mod", 32, n);
    acc(0, 4'h4, 0); chk("stat oos", 32'h7f, q);
    acc(1, 4'h4, 32'h7c); acc(0, 4'h4, 0);
    chk("stat w1c", 32'h07, q);
    acc(0, 4'h5, 0); chk("temp read", 32'h17f00, q);
    acc(1, 4'h0, 32'h47); repeat (3) @(posedge i_clk);
    chk("irq oos", 1, irq);
    heat(2'h0); pull <= 1'b1; repeat (300) @(posedge i_clk);
    chk("ext step", 1, perf);
    cnt(0, n); chk("ext no force", 64, n);
    acc(1, 4'h0, 32'h1); repeat (20) @(posedge i_clk);
    cnt(0, n); chk("ext core0", 32, n);
    cnt(1, n); chk("ext core1", 32, n);
    @(posedge i_clk);
    pull <= 1'b0; lp <= 1'b1; repeat (5) @(posedge i_clk); heat(2'h3);
    chk("lp alert", 0, poe);
    heat(2'h0); lp <= 1'b0; cat <= 1'b1; repeat (5) @(posedge i_clk);
    chk("trip", 1, trip);
    end_of_test;
  end
endmodule // ttc_top_tb
